// File: hdl/tcc_pkg.sv
package tcc_pkg;
    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int NCH   = 48;
    localparam int NSET  = 16;
    localparam int SETW  = 4;
    localparam int DEPTH = 512;
    localparam int AW    = 9;
    localparam int DLYW  = 16;

    localparam logic [AW-1:0]   ADDR_LAST = 9'h1ff;
    localparam logic [AW-1:0]   ADDR_ZERO = 9'h000;
    localparam logic [SETW-1:0] SET_FIRST = 4'h0;
    localparam logic [DLYW-1:0] DLY_ZERO  = 16'h0000;
    localparam logic [DLYW-1:0] DLY_ONE   = 16'h0001;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS     = 40;
    localparam int SMP_MIN_NS = 10;
    localparam int SMP_CYC_RAW = (SMP_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SMP_CYC = (SMP_CYC_RAW < 1) ? 1 : SMP_CYC_RAW;

    // ------------------------------------------------------------
    // per-set action on a pattern hit
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_STOP = 2'b01,
        ACT_DLY  = 2'b10,
        ACT_FILL = 2'b11
    } tcc_act_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RUN  = 3'b001,
        S_DONE = 3'b010,
        S_COPY = 3'b011,
        S_SRCH = 3'b100,
        S_CMP  = 3'b101
    } tcc_state_e;
endpackage : tcc_pkg

// File: hdl/tcc_core.sv
`timescale 1ns/1ns
module tcc_core
    import tcc_pkg::*;
(
    // clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            rst_b_i,
    // qualified samples from the probes
    input  wire logic [NCH-1:0]  sample_i,
    input  wire logic            sample_vld_i,
    // spec set programming
    input  wire logic            cfg_we_i,
    input  wire logic [SETW-1:0] cfg_idx_i,
    input  wire logic [NCH-1:0]  cfg_val_i,
    input  wire logic [NCH-1:0]  cfg_care_i,
    input  wire logic            cfg_st_hit_i,
    input  wire logic            cfg_st_miss_i,
    input  wire logic [1:0]      cfg_act_i,
    input  wire logic            cfg_jump_i,
    input  wire logic [SETW-1:0] cfg_nxt_i,
    input  wire logic [DLYW-1:0] dly_cnt_i,
    // commands
    input  wire logic            start_i,
    input  wire logic            copy_i,
    input  wire logic            search_i,
    input  wire logic            srch_ref_i,
    input  wire logic [NCH-1:0]  srch_val_i,
    input  wire logic [NCH-1:0]  srch_care_i,
    input  wire logic            cmp_i,
    // reference edit and memory read
    input  wire logic            ref_we_i,
    input  wire logic [AW-1:0]   ref_addr_i,
    input  wire logic [NCH-1:0]  ref_data_i,
    input  wire logic [AW-1:0]   rd_addr_i,
    input  wire logic            rd_ref_i,
    output logic [NCH-1:0]       rd_data_o,
    // status
    output logic                 running_o,
    output logic                 done_o,
    output logic                 wrap_o,
    output logic [AW-1:0]        wr_ptr_o,
    output logic [SETW-1:0]      set_o,
    output logic                 op_busy_o,
    output logic                 op_done_o,
    output logic                 hit_o,
    output logic [AW-1:0]        hit_addr_o
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [NCH-1:0]  set_val  [NSET];
    logic [NCH-1:0]  set_care [NSET];
    logic            set_sth  [NSET];
    logic            set_stm  [NSET];
    tcc_act_e        set_act  [NSET];
    logic            set_jmp  [NSET];
    logic [SETW-1:0] set_nxt  [NSET];
    logic [NCH-1:0]  trc_mem  [DEPTH];
    logic [NCH-1:0]  ref_mem  [DEPTH];

    tcc_state_e      st_reg;
    logic [SETW-1:0] set_reg;
    logic [AW-1:0]   wp_reg;
    logic            wrap_reg;
    logic            dly_on_reg;
    logic [DLYW-1:0] dly_reg;
    logic            fill_on_reg;
    logic [AW-1:0]   fill_reg;
    logic [AW-1:0]   op_reg;
    logic            srch_ref_reg;
    logic [NCH-1:0]  sv_reg;
    logic [NCH-1:0]  sc_reg;

    // ------------------------------------------------------------
    // spec set table
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NSET; g++) begin : g_set
            always_ff @(posedge core_clk_i) begin
                if (!rst_b_i) begin
                    set_val[g]  <= '0;
                    set_care[g] <= '0;
                    set_sth[g]  <= 1'b1;
                    set_stm[g]  <= 1'b1;
                    set_act[g]  <= ACT_NONE;
                    set_jmp[g]  <= 1'b0;
                    set_nxt[g]  <= SET_FIRST;
                end else if (cfg_we_i && cfg_idx_i == SETW'(g)) begin
                    set_val[g]  <= cfg_val_i;
                    set_care[g] <= cfg_care_i;
                    set_sth[g]  <= cfg_st_hit_i;
                    set_stm[g]  <= cfg_st_miss_i;
                    set_act[g]  <= tcc_act_e'(cfg_act_i);
                    set_jmp[g]  <= cfg_jump_i;
                    set_nxt[g]  <= cfg_nxt_i;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // per-sample decision
    // ------------------------------------------------------------
    logic     smp;
    logic     hit;
    logic     store_now;
    logic     stop_now;
    tcc_act_e act;

    assign smp = (st_reg == S_RUN) && sample_vld_i;
    assign act = set_act[set_reg];
    assign hit = ((sample_i ^ set_val[set_reg])
                  & set_care[set_reg]) == '0;

    always_comb begin
        store_now = 1'b0;
        stop_now  = 1'b0;
        if (smp) begin
            // once filling, every sample goes in regardless of set
            if (fill_on_reg || (hit && act == ACT_FILL))
                store_now = 1'b1;
            else
                store_now = hit ? set_sth[set_reg]
                                : set_stm[set_reg];
            if (hit && act == ACT_STOP)
                stop_now = 1'b1;
            if (dly_on_reg && dly_reg <= DLY_ONE)
                stop_now = 1'b1;
            if (!dly_on_reg && hit && act == ACT_DLY
                && dly_cnt_i == DLY_ZERO)
                stop_now = 1'b1;
            if (fill_on_reg && fill_reg == ADDR_LAST)
                stop_now = 1'b1;
            if (!fill_on_reg && hit && act == ACT_FILL
                && ADDR_ZERO == ADDR_LAST)
                stop_now = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    logic op_end;
    logic [NCH-1:0] scan_word;
    logic scan_hit;

    assign scan_word = srch_ref_reg ? ref_mem[op_reg] : trc_mem[op_reg];
    always_comb begin
        scan_hit = 1'b0;
        if (st_reg == S_SRCH)
            scan_hit = ((scan_word ^ sv_reg) & sc_reg) == '0;
        else if (st_reg == S_CMP)
            scan_hit = trc_mem[op_reg] != ref_mem[op_reg];
    end
    assign op_end = scan_hit || op_reg == ADDR_LAST;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_reg <= S_IDLE;
        end else begin
            case (st_reg)
                S_IDLE, S_DONE: begin
                    if (start_i)
                        st_reg <= S_RUN;
                    else if (copy_i)
                        st_reg <= S_COPY;
                    else if (search_i)
                        st_reg <= S_SRCH;
                    else if (cmp_i)
                        st_reg <= S_CMP;
                end
                S_RUN:  if (stop_now) st_reg <= S_DONE;
                S_COPY: if (op_reg == ADDR_LAST) st_reg <= S_DONE;
                S_SRCH, S_CMP: if (op_end) st_reg <= S_DONE;
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    logic idle;
    assign idle = (st_reg == S_IDLE) || (st_reg == S_DONE);

    // set selection, pointer and counters
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            set_reg     <= SET_FIRST;
            wp_reg      <= ADDR_ZERO;
            wrap_reg    <= 1'b0;
            dly_on_reg  <= 1'b0;
            dly_reg     <= DLY_ZERO;
            fill_on_reg <= 1'b0;
            fill_reg    <= ADDR_ZERO;
        end else if (idle && start_i) begin
            set_reg     <= SET_FIRST;
            wp_reg      <= ADDR_ZERO;
            wrap_reg    <= 1'b0;
            dly_on_reg  <= 1'b0;
            dly_reg     <= DLY_ZERO;
            fill_on_reg <= 1'b0;
            fill_reg    <= ADDR_ZERO;
        end else if (smp) begin
            if (hit && set_jmp[set_reg])
                set_reg <= set_nxt[set_reg];
            if (store_now) begin
                wp_reg <= wp_reg + 9'h001;
                if (wp_reg == ADDR_LAST)
                    wrap_reg <= 1'b1;
            end
            // a second delay hit while counting does not restart it
            if (dly_on_reg)
                dly_reg <= dly_reg - DLY_ONE;
            else if (hit && act == ACT_DLY) begin
                dly_on_reg <= 1'b1;
                dly_reg    <= dly_cnt_i;
            end
            // the hit sample is entry 0, so the next one is entry 1
            if (fill_on_reg)
                fill_reg <= fill_reg + 9'h001;
            else if (hit && act == ACT_FILL) begin
                fill_on_reg <= 1'b1;
                fill_reg    <= 9'h001;
            end
        end
    end

    // trace memory write; no write outside RUN keeps it frozen
    always_ff @(posedge core_clk_i) begin
        if (store_now)
            trc_mem[wp_reg] <= sample_i;
    end

    // reference memory: copy has priority over single-entry edits
    always_ff @(posedge core_clk_i) begin
        if (st_reg == S_COPY)
            ref_mem[op_reg] <= trc_mem[op_reg];
        else if (ref_we_i)
            ref_mem[ref_addr_i] <= ref_data_i;
    end

    // ------------------------------------------------------------
    // scan engine for copy, search and compare
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            op_reg       <= ADDR_ZERO;
            srch_ref_reg <= 1'b0;
            sv_reg       <= '0;
            sc_reg       <= '0;
            op_done_o    <= 1'b0;
            hit_o        <= 1'b0;
            hit_addr_o   <= ADDR_ZERO;
        end else begin
            op_done_o <= 1'b0;
            if (idle && !start_i && (copy_i || search_i || cmp_i)) begin
                op_reg       <= ADDR_ZERO;
                srch_ref_reg <= srch_ref_i;
                sv_reg       <= srch_val_i;
                sc_reg       <= srch_care_i;
                hit_o        <= 1'b0;
            end else if (st_reg == S_COPY) begin
                op_reg <= op_reg + 9'h001;
                if (op_reg == ADDR_LAST)
                    op_done_o <= 1'b1;
            end else if (st_reg == S_SRCH || st_reg == S_CMP) begin
                op_reg <= op_reg + 9'h001;
                if (op_end) begin
                    op_done_o  <= 1'b1;
                    hit_o      <= scan_hit;
                    hit_addr_o <= op_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // readback and status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            rd_data_o <= '0;
        else
            rd_data_o <= rd_ref_i ? ref_mem[rd_addr_i] : trc_mem[rd_addr_i];
    end

    assign running_o = st_reg == S_RUN;
    assign done_o    = st_reg == S_DONE;
    assign op_busy_o = (st_reg == S_COPY) || (st_reg == S_SRCH)
                       || (st_reg == S_CMP);
    assign wrap_o    = wrap_reg;
    assign wr_ptr_o  = wp_reg;
    assign set_o     = set_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence start_s;
        idle && start_i;
    endsequence
    sequence frozen_s;
        !running_o && $stable(wp_reg);
    endsequence

    start_init_a: assert property (start_s |=> running_o
        && set_reg == SET_FIRST && wp_reg == ADDR_ZERO)
        else $error("start did not reset set and pointer");
    store_word_a: assert property (store_now |=>
        trc_mem[$past(wp_reg)] == $past(sample_i))
        else $error("stored word differs from sample");
    ring_wrap_a: assert property (store_now
        && wp_reg == ADDR_LAST |=> wp_reg == ADDR_ZERO && wrap_reg)
        else $error("pointer did not wrap");
    stop_freeze_a: assert property (smp && hit
        && act == ACT_STOP |=> !running_o ##1 frozen_s)
        else $error("stop did not freeze trace");
    jump_set_a: assert property (smp && hit
        && set_jmp[set_reg] |=> set_reg == $past(set_nxt[set_reg]))
        else $error("set transfer missed");
    dly_end_a: assert property (smp && dly_on_reg
        && dly_reg == DLY_ONE |=> st_reg == S_DONE)
        else $error("delayed stop late");
    fill_end_a: assert property (smp && fill_on_reg
        && fill_reg == ADDR_LAST |=> done_o)
        else $error("fill stop late");
    ref_edit_a: assert property (ref_we_i && idle
        |=> ref_mem[$past(ref_addr_i)] == $past(ref_data_i))
        else $error("reference write lost");
    op_bound_a: assert property (idle && !start_i
        && (search_i || cmp_i || copy_i) |-> ##[1:515] op_done_o)
        else $error("scan did not finish");
endmodule : tcc_core

// File: bench/tcc_probe_src.sv
`timescale 1ns/1ns
module tcc_probe_src
    import tcc_pkg::*;
(
    // clock and pacing
    input  wire logic           core_clk_i,
    input  wire logic           en_i,
    input  wire logic [NCH-1:0] base_i,
    // probe side
    output logic [NCH-1:0]      sample_o,
    output logic                sample_vld_o
);
    logic [15:0]    cnt_reg;
    logic [NCH-1:0] last_reg;

    // low bits step each sample so every stored word is distinct
    assign sample_vld_o = en_i;
    // idle probes show the inverse of the previous output, so the last sample and its inverse alternate while idle
    assign sample_o = en_i ? (base_i ^ NCH'(cnt_reg)) : ~last_reg;

    always_ff @(posedge core_clk_i) begin
        cnt_reg  <= en_i ? cnt_reg + 16'h0001 : 16'h0000;
        last_reg <= sample_o;
    end
endmodule : tcc_probe_src

// File: bench/trace_capture_control_tb_top.sv
`timescale 1ns/1ns
module trace_capture_control_tb_top
    import tcc_pkg::*;
;
    typedef struct {
        logic [NCH-1:0] val;
        logic [NCH-1:0] care;
        logic [NCH-1:0] word;
        logic           hit;
    } tcc_row_s;

    logic            core_clk_i, rst_b_i, sample_vld_i, probe_en;
    logic [NCH-1:0]  sample_i, probe_word, rd_data_o;
    logic [NCH-1:0]  cfg_val_i, cfg_care_i, srch_val_i, srch_care_i;
    logic [NCH-1:0]  ref_data_i, got;
    logic            cfg_we_i, cfg_st_hit_i, cfg_st_miss_i, cfg_jump_i;
    logic [SETW-1:0] cfg_idx_i, cfg_nxt_i, set_o;
    logic [1:0]      cfg_act_i, st_mask;
    logic [DLYW-1:0] dly_cnt_i;
    logic            start_i, copy_i, search_i, srch_ref_i, cmp_i;
    logic            ref_we_i, rd_ref_i, running_o, done_o, wrap_o;
    logic [AW-1:0]   ref_addr_i, rd_addr_i, wr_ptr_o, hit_addr_o;
    logic            op_busy_o, op_done_o, hit_o;
    int              mismatches, samples_checked;
    tcc_row_s        rows [5];

    localparam logic [NCH-1:0] ALL = 48'hffff_ffff_ffff;
    localparam logic [NCH-1:0] TOP = 48'h8000_0000_0000;
    localparam logic [NCH-1:0] HW  = 48'h8000_0000_1234;

    tcc_probe_src tcc_probe_src_inst (
        .core_clk_i   (core_clk_i),
        .en_i         (probe_en),
        .base_i       (probe_word),
        .sample_o     (sample_i),
        .sample_vld_o (sample_vld_i)
    );

    tcc_core tcc_core_inst (
        .core_clk_i    (core_clk_i),
        .rst_b_i       (rst_b_i),
        .sample_i      (sample_i),
        .sample_vld_i  (sample_vld_i),
        .cfg_we_i      (cfg_we_i),
        .cfg_idx_i     (cfg_idx_i),
        .cfg_val_i     (cfg_val_i),
        .cfg_care_i    (cfg_care_i),
        .cfg_st_hit_i  (cfg_st_hit_i),
        .cfg_st_miss_i (cfg_st_miss_i),
        .cfg_act_i     (cfg_act_i),
        .cfg_jump_i    (cfg_jump_i),
        .cfg_nxt_i     (cfg_nxt_i),
        .dly_cnt_i     (dly_cnt_i),
        .start_i       (start_i),
        .copy_i        (copy_i),
        .search_i      (search_i),
        .srch_ref_i    (srch_ref_i),
        .srch_val_i    (srch_val_i),
        .srch_care_i   (srch_care_i),
        .cmp_i         (cmp_i),
        .ref_we_i      (ref_we_i),
        .ref_addr_i    (ref_addr_i),
        .ref_data_i    (ref_data_i),
        .rd_addr_i     (rd_addr_i),
        .rd_ref_i      (rd_ref_i),
        .rd_data_o     (rd_data_o),
        .running_o     (running_o),
        .done_o        (done_o),
        .wrap_o        (wrap_o),
        .wr_ptr_o      (wr_ptr_o),
        .set_o         (set_o),
        .op_busy_o     (op_busy_o),
        .op_done_o     (op_done_o),
        .hit_o         (hit_o),
        .hit_addr_o    (hit_addr_o)
    );

    // ------------------------------------------------------------
    // clock and tasks
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input string nm, input logic [NCH-1:0] ex, gt);
        samples_checked++;
        if (gt !== ex) begin
            $display("wrong value %s expected %h seen %h", nm, ex, gt);
            mismatches++;
        end
    endtask : chk

    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic do_reset();
        rst_b_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        rst_b_i = 1'b1;
    endtask : do_reset

    task automatic cfg(input logic [SETW-1:0] idx, input logic [NCH-1:0] v,
                       c, input logic [1:0] a, input logic j,
                       input logic [SETW-1:0] nx);
        @(negedge core_clk_i);
        {cfg_idx_i, cfg_val_i, cfg_care_i, cfg_act_i} = {idx, v, c, a};
        {cfg_st_hit_i, cfg_st_miss_i, cfg_jump_i, cfg_nxt_i} = {st_mask, j, nx};
        cfg_we_i = 1'b1;
        @(negedge core_clk_i);
        cfg_we_i = 1'b0;
    endtask : cfg

    // one command pulse: start, copy, search, compare
    task automatic cmd(input logic [3:0] m);
        @(negedge core_clk_i);
        {start_i, copy_i, search_i, cmp_i} = m;
        @(negedge core_clk_i);
        {start_i, copy_i, search_i, cmp_i} = 4'h0;
    endtask : cmd

    task automatic feed(input logic [NCH-1:0] w, input int n);
        probe_word = w;
        probe_en = 1'b1;
        repeat (n) @(negedge core_clk_i);
        probe_en = 1'b0;
    endtask : feed

    task automatic wait_op();
        int k;
        k = 0;
        // op_done_o stands from edge to edge, so the falling edge sees it
        while (op_done_o !== 1'b1 && k < 600) begin
            @(negedge core_clk_i);
            k++;
        end
        chk("op_end", NCH'(3'h5), NCH'({op_done_o, op_busy_o, done_o}));
    endtask : wait_op

    // readback is registered: one edge between select and data
    task automatic rd(input logic r, input logic [AW-1:0] a);
        @(negedge core_clk_i);
        {rd_ref_i, rd_addr_i} = {r, a};
        @(negedge core_clk_i);
        got = rd_data_o;
    endtask : rd

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {mismatches, samples_checked} = '0;
        {cfg_we_i, cfg_st_hit_i, cfg_st_miss_i, cfg_jump_i, start_i} = '0;
        {copy_i, search_i, srch_ref_i, cmp_i, ref_we_i, rd_ref_i} = '0;
        {cfg_val_i, cfg_care_i, srch_val_i, srch_care_i} = '0;
        {ref_data_i, probe_word, probe_en} = '0;
        {cfg_idx_i, cfg_nxt_i, cfg_act_i, dly_cnt_i} = '0;
        {ref_addr_i, rd_addr_i} = '0;
        st_mask = 2'b11;
        rst_b_i = 1'b0;
        rows[0] = '{48'ha5a5_0f0f_3c3c, ALL, 48'ha5a5_0f0f_3c3c, 1'b1};
        rows[1] = '{48'ha5a5_0f0f_3c3c, ALL, 48'ha5a5_0f0f_3c3e, 1'b0};
        rows[2] = '{48'h1234_5678_9abc, '0, 48'h0000_ffff_0000, 1'b1};
        rows[3] = '{TOP, TOP, 48'hfedc_ba98_7654, 1'b1};
        rows[4] = '{TOP, TOP, 48'h7edc_ba98_7654, 1'b0};
        do_reset();
        chk("reset", '0, NCH'({running_o, done_o, wr_ptr_o, set_o}));
        // pattern table: stop on hit stores one word and freezes
        foreach (rows[i]) begin
            do_reset();
            cfg(SET_FIRST, rows[i].val, rows[i].care, ACT_STOP, 1'b0, 4'h0);
            cmd(4'h8);
            feed(rows[i].word, 2);
            chk("running", NCH'(!rows[i].hit), NCH'(running_o));
            chk("wr_ptr", rows[i].hit ? NCH'(1) : NCH'(2), NCH'(wr_ptr_o));
        end
        // jump to another set, then a fresh start returns to set 0
        do_reset();
        cfg(SET_FIRST, TOP, TOP, ACT_NONE, 1'b1, 4'h9);
        cfg(4'h9, '0, '0, ACT_STOP, 1'b0, 4'h0);
        cmd(4'h8);
        feed(HW, 1);
        chk("set", NCH'(5'h19), NCH'({running_o, set_o}));
        @(negedge core_clk_i);
        feed('0, 1);
        chk("wr_ptr", NCH'(2), NCH'({running_o, wr_ptr_o}));
        cmd(4'h8);
        chk("restart", NCH'(14'h2000),
            NCH'({running_o, wr_ptr_o, set_o}));
        // delayed stop: hit plus three more samples
        do_reset();
        dly_cnt_i = 16'h0003;
        cfg(SET_FIRST, TOP, TOP, ACT_DLY, 1'b0, 4'h0);
        cmd(4'h8);
        feed(HW, 6);
        chk("delay", NCH'(11'h204), NCH'({running_o, done_o, wr_ptr_o}));
        // post-trigger fill from the hit, 512 words, ring wraps once
        do_reset();
        st_mask = 2'b00;
        cfg(SET_FIRST, TOP, TOP, ACT_FILL, 1'b0, 4'h0);
        st_mask = 2'b11;
        cmd(4'h8);
        feed(48'h0000_0000_1234, 5);
        chk("pre_trig", '0, NCH'(wr_ptr_o));
        // one idle cycle restarts the probe count, so entry k holds HW ^ k
        @(negedge core_clk_i);
        feed(HW, 514);
        chk("fill", NCH'(10'h200),
            NCH'({running_o, wrap_o, wr_ptr_o}));
        rd(1'b0, 9'h000);
        chk("trace0", HW, got);
        rd(1'b0, 9'h005);
        chk("trace5", HW ^ 48'h5, got);
        // copy, edit one reference entry, compare and search
        cmd(4'h4);
        wait_op();
        rd(1'b1, 9'h005);
        chk("ref5", HW ^ 48'h5, got);
        @(negedge core_clk_i);
        {ref_we_i, ref_addr_i, ref_data_i} = {1'b1, 9'h007, 48'h0};
        @(negedge core_clk_i);
        ref_we_i = 1'b0;
        cmd(4'h1);
        chk("busy", NCH'(1), NCH'(op_busy_o));
        wait_op();
        chk("cmp", NCH'(10'h207), NCH'({hit_o, hit_addr_o}));
        {srch_ref_i, srch_val_i, srch_care_i} = {1'b1, 48'h0, ALL};
        cmd(4'h2);
        wait_op();
        chk("srch_ref", NCH'(10'h207), NCH'({hit_o, hit_addr_o}));
        {srch_ref_i, srch_val_i} = {1'b0, HW ^ 48'h9};
        cmd(4'h2);
        wait_op();
        chk("srch_tr", NCH'(10'h209), NCH'({hit_o, hit_addr_o}));
        finish_test();
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (8000) @(posedge core_clk_i);
        mismatches++;
        finish_test();
    end
endmodule : trace_capture_control_tb_top
